// >>> src/uart_autobaud_and_break_wake.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - setting autobaud enable starts calibration; receiver held idle meanwhile
// - counter starts counting at first rising edge after start bit
// - at fifth rising edge: keep count, clear enable, set receive flag
// - high and low divisor bytes form one 16-bit counter while calibrating
// - counter clock: 00 osc/512, 01 and 10 osc/128, 11 osc/32
// - counter advances at one eighth of the baud base clock
// - counter starts at one; software subtracts one afterwards
// - reading receive data clears receive flag; value discarded
// - high byte holds count above low byte; 00h means no overflow
// - overflow flag set on wrap; counting continues until fifth edge
// - software clears overflow, but only once enable is cleared
// - with wake and autobaud, calibrate the character after the break
// - wake enable disables reception and watches for falling edge
// - wake on break works only in asynchronous mode
// - wake event sets receive flag at once
// - reading receive data clears pending wake interrupt
// - wake enable clears itself on rising edge ending the break
// - non-zero character: low time to first rise is the wake event
module uart_autobaud_and_break_wake
    import autobaud_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial line and receiver handshake
    input  wire logic        serial_receive_line,
    input  wire logic [7:0]  rx_char,
    input  wire logic        receiver_busy,
    output logic             receiver_hold_idle,
    output logic             receive_irq_flag
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    logic        autobaud_enable;
    logic        wake_on_break_enable;
    logic        wide_divisor_select;
    logic        high_speed_select;
    logic        sync_mode;
    logic        autobaud_overflow_flag;
    logic [15:0] baud_divisor;
    logic [2:0]  rise_count;
    logic        wake_seen;
    cal_state_t  cal_state;

    logic        line_rise;
    logic        line_fall;
    logic        cal_tick;

    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    ////////////////////////////////////////////////////////////////////////////
    // line synchroniser and calibration tick
    sync_edge line_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (serial_receive_line),
        .level    (),
        .rise     (line_rise),
        .fall     (line_fall)
    );

    cal_prescaler prescaler (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .run                 (cal_state == cal_count),
        .wide_divisor_select (wide_divisor_select),
        .high_speed_select   (high_speed_select),
        .tick                (cal_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    // one address map for both channels
    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == ctrl_addr) || (a == divisor_addr) ||
               (a == rx_data_addr) || (a == status_addr);
    endfunction : reg_mapped

    wire        wr_fire   = aw_held && w_held && !s_axi_bvalid;
    wire        wr_ctrl   = wr_fire && (aw_addr == ctrl_addr) && w_strb[0];
    wire        wr_div    = wr_fire && (aw_addr == divisor_addr);
    wire        wr_known  = reg_mapped(aw_addr);
    wire        rd_fire   = s_axi_arvalid && s_axi_arready;
    wire        rd_rxdata = rd_fire && (s_axi_araddr == rx_data_addr);
    wire        wake_mode = wake_on_break_enable && !sync_mode;
    wire        calibrating = (cal_state != cal_idle);

    // wake event: falling edge while armed and not yet seen
    wire        wake_event = wake_mode && !wake_seen && line_fall;
    // rising edge that ends the break
    wire        wake_done  = wake_mode && wake_seen && line_rise;
    // calibration waits out any pending break first
    wire        cal_armed  = autobaud_enable && !wake_on_break_enable;
    wire        fifth_rise = (cal_state == cal_count) && line_rise &&
                             (rise_count == rising_edges_end - 3'h1);
    // a tick landing on the fifth edge is not a pass beyond the maximum
    wire        wrap       = (cal_state == cal_count) && cal_tick && !fifth_rise &&
                             (baud_divisor == 16'hFFFF);

    ////////////////////////////////////////////////////////////////////////////
    // control register
    wire        next_enable_clear = fifth_rise;
    wire        sw_overflow_clear = wr_ctrl && !w_data[ctrl_overflow_bit] &&
                                    !w_data[ctrl_autobaud_enable_bit] && !autobaud_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            autobaud_enable      <= 1'b0;
            wake_on_break_enable <= 1'b0;
            wide_divisor_select  <= 1'b0;
            high_speed_select    <= 1'b0;
            sync_mode            <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                autobaud_enable      <= w_data[ctrl_autobaud_enable_bit];
                wake_on_break_enable <= w_data[ctrl_wake_enable_bit];
                wide_divisor_select  <= w_data[ctrl_wide_divisor_bit];
                high_speed_select    <= w_data[ctrl_high_speed_bit];
                sync_mode            <= w_data[ctrl_sync_mode_bit];
            end
            // hardware clears win over a simultaneous write
            if (next_enable_clear) begin
                autobaud_enable <= 1'b0;
            end
            if (wake_done) begin
                wake_on_break_enable <= 1'b0;
            end
        end
    end

    // overflow: set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            autobaud_overflow_flag <= 1'b0;
        end else if (wrap) begin
            autobaud_overflow_flag <= 1'b1;
        end else if (sw_overflow_clear) begin
            autobaud_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_seen <= 1'b0;
        end else if (!wake_mode || wake_done) begin
            wake_seen <= 1'b0;
        end else if (wake_event) begin
            wake_seen <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // calibration sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_state  <= cal_idle;
            rise_count <= 3'h0;
        end else if (!cal_armed) begin
            cal_state  <= cal_idle;
            rise_count <= 3'h0;
        end else begin
            unique case (cal_state)
                cal_idle: begin
                    cal_state <= cal_wait_start;
                end
                cal_wait_start: begin
                    if (line_rise) begin
                        cal_state  <= cal_count;
                        rise_count <= 3'h1;
                    end
                end
                cal_count: begin
                    if (fifth_rise) begin
                        cal_state  <= cal_idle;
                        rise_count <= 3'h0;
                    end else if (line_rise) begin
                        rise_count <= rise_count + 3'h1;
                    end
                end
            endcase
        end
    end

    // one 16-bit counter; high byte carries any low-byte overflow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_divisor <= 16'h0000;
        end else if (cal_armed && cal_state == cal_wait_start && line_rise) begin
            baud_divisor <= counter_start;
        end else if (cal_state == cal_count && cal_tick && !fifth_rise) begin
            baud_divisor <= baud_divisor + 16'h0001;
        end else if (wr_div && !calibrating) begin
            if (w_strb[0]) begin
                baud_divisor[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
                baud_divisor[15:8] <= w_data[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive flag: events win over the clearing read
    wire irq_set = fifth_rise || wake_event;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            receive_irq_flag <= 1'b0;
        end else if (irq_set) begin
            receive_irq_flag <= 1'b1;
        end else if (rd_rxdata) begin
            receive_irq_flag <= 1'b0;
        end
    end

    // receiver held idle while calibrating or armed for wake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            receiver_hold_idle <= 1'b0;
        end else begin
            receiver_hold_idle <= autobaud_enable || wake_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? resp_okay : resp_slverr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ready flops carry the decode of the next held and response state
    wire        next_aw_held = (aw_held || (s_axi_awvalid && s_axi_awready)) && !wr_fire;
    wire        next_w_held  = (w_held || (s_axi_wvalid && s_axi_wready)) && !wr_fire;
    wire        next_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read path
    wire [7:0]  rd_addr = {s_axi_araddr[7:2], 2'b00};
    wire [31:0] ctrl_word = {24'h00_0000, autobaud_overflow_flag, 2'b00, sync_mode,
                             high_speed_select, wide_divisor_select, wake_on_break_enable, autobaud_enable};
    wire [31:0] status_word = {29'h0000_0000, autobaud_overflow_flag,
                               !receiver_busy && !calibrating, receive_irq_flag};
    wire        rd_known = reg_mapped(rd_addr);
    wire [31:0] rd_word = (rd_addr == ctrl_addr)    ? ctrl_word :
                          (rd_addr == divisor_addr) ? {16'h0000, baud_divisor} :
                          (rd_addr == rx_data_addr) ? {24'h00_0000, rx_char} :
                          (rd_addr == status_addr)  ? status_word : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= resp_okay;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_known ? resp_okay : resp_slverr;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : uart_autobaud_and_break_wake

// >>> pkg/autobaud_pkg.sv
package autobaud_pkg;

    // register byte addresses
    localparam logic [7:0] ctrl_addr        = 8'h00;
    localparam logic [7:0] divisor_addr     = 8'h04;
    localparam logic [7:0] rx_data_addr     = 8'h08;
    localparam logic [7:0] status_addr      = 8'h0C;

    // control register fields
    localparam int ctrl_autobaud_enable_bit   = 0;
    localparam int ctrl_wake_enable_bit       = 1;
    localparam int ctrl_wide_divisor_bit      = 2;
    localparam int ctrl_high_speed_bit        = 3;
    localparam int ctrl_sync_mode_bit         = 4;
    localparam int ctrl_overflow_bit          = 7;

    // status register fields
    localparam int status_irq_bit             = 0;
    localparam int status_idle_bit            = 1;
    localparam int status_overflow_bit        = 2;

    // divider reload values (oscillator / n, minus one)
    localparam logic [8:0] div_512            = 9'h1FF;
    localparam logic [8:0] div_128            = 9'h07F;
    localparam logic [8:0] div_32             = 9'h01F;

    localparam logic [15:0] counter_start     = 16'h0001;
    localparam logic [2:0]  rising_edges_end  = 3'h5;

    localparam logic [1:0] resp_okay          = 2'b00;
    localparam logic [1:0] resp_slverr        = 2'b10;

    typedef enum logic [1:0] {
        cal_idle,
        cal_wait_start,
        cal_count
    } cal_state_t;

endpackage : autobaud_pkg

// >>> src/sync_edge.sv
`timescale 1ns/1ps
// two-flop synchroniser with rising and falling edge pulses
module sync_edge
    import autobaud_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // raw line and results
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic stage;
    logic prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta  <= 1'b1;
            stage <= 1'b1;
            prev  <= 1'b1;
        end else begin
            meta  <= async_in;
            stage <= meta;
            prev  <= stage;
        end
    end

    assign level = stage;
    assign rise  = !prev && stage;
    assign fall  = prev && !stage;
endmodule : sync_edge

// >>> src/cal_prescaler.sv
`timescale 1ns/1ps
// calibration tick divider: one pulse per selected oscillator division
module cal_prescaler
    import autobaud_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control
    input  wire logic run,
    input  wire logic wide_divisor_select,
    input  wire logic high_speed_select,
    // tick out
    output logic      tick
);
    logic [8:0] count;
    wire  [1:0] sel = {wide_divisor_select, high_speed_select};
    wire  [8:0] reload;

    // base clock divided by a further eight
    assign reload = (sel == 2'b00) ? div_512 :
                    (sel == 2'b11) ? div_32  : div_128;

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count <= 9'h000;
        end else if (count >= reload) begin
            count <= 9'h000;
        end else begin
            count <= count + 9'h001;
        end
    end

    assign tick = run && (count >= reload);
endmodule : cal_prescaler

// >>> dv/uart_autobaud_and_break_wake_sva.sv
`timescale 1ns/1ps
module uart_autobaud_and_break_wake_sva
    import autobaud_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // line and receiver side
    input wire logic        serial_receive_line,
    input wire logic [7:0]  rx_char,
    input wire logic        receiver_hold_idle,
    input wire logic        receive_irq_flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    // ages saturate so a long quiet spell never wraps into a match
    logic       line_q;
    logic [3:0] line_age;
    logic [3:0] wr_age;
    logic [3:0] rd_age;
    logic [7:0] rd_addr;
    wire        line_moved = line_q != serial_receive_line;
    wire        rd_taken   = s_axi_arvalid && s_axi_arready;
    wire        rx_read    = rd_taken && s_axi_araddr == rx_data_addr;
    always_ff @(posedge aclk) begin
        line_q <= serial_receive_line;
        if (!aresetn) begin
            line_age <= 4'hF;
            wr_age   <= 4'hF;
            rd_age   <= 4'hF;
            rd_addr  <= 8'h00;
        end else begin
            line_age <= line_moved ? 4'h0 : line_age + {3'h0, line_age != 4'hF};
            wr_age   <= (s_axi_wvalid && s_axi_wready) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hF};
            rd_age   <= rx_read ? 4'h0 : rd_age + {3'h0, rd_age != 4'hF};
            if (rd_taken) rd_addr <= s_axi_araddr;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_irq_rise;
        $rose(receive_irq_flag) |-> line_age <= 4'h8;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("receive flag rose with no line edge");
    property p_irq_fall;
        $fell(receive_irq_flag) |-> rd_age <= 4'h3;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("receive flag fell with no data read");
    property p_idle_rise;
        $rose(receiver_hold_idle) |-> wr_age <= 4'h3;
    endproperty
    a_idle_rise: assert property (p_idle_rise) else $error("receiver held idle with no write");
    property p_idle_fall;
        $fell(receiver_hold_idle) |-> line_age <= 4'h8 || wr_age <= 4'h3;
    endproperty
    a_idle_fall: assert property (p_idle_fall) else $error("receiver released with no cause");
    property p_rx_data;
        $rose(s_axi_rvalid) && rd_addr == rx_data_addr |-> s_axi_rdata[7:0] == rx_char;
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("data read does not return the byte");
    property p_unmapped;
        $rose(s_axi_rvalid) && rd_addr[7:4] != 4'h0 |-> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_read_answer;
        rd_taken |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_no_accept;
        s_axi_bvalid |-> !s_axi_wready;
    endproperty
    a_no_accept: assert property (p_no_accept) else $error("write data taken with response pending");
endmodule : uart_autobaud_and_break_wake_sva

bind uart_autobaud_and_break_wake uart_autobaud_and_break_wake_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .serial_receive_line(serial_receive_line), .rx_char(rx_char),
    .receiver_hold_idle(receiver_hold_idle), .receive_irq_flag(receive_irq_flag)
);

// >>> dv/serial_sender.sv
`timescale 1ns/1ps
module serial_sender (
    // clock
    input  wire logic aclk,
    // line toward the receiver, idle high
    output logic      line
);
    initial line = 1'b1;
    // lsb first, each bit held bcyc clocks; line keeps the last bit
    task automatic send(input logic [15:0] bits, input int n, input int bcyc);
        for (int i = 0; i < n; i++) begin
            line <= bits[i];
            repeat (bcyc) @(posedge aclk);
        end
    endtask : send
    task automatic sync_char(input int bcyc);
        send(16'h02AA, 10, bcyc);
    endtask : sync_char
    // caller ends the break, so checks can run while the line is low
    task automatic brk(input int bcyc);
        send(16'h0000, 13, bcyc);
    endtask : brk
endmodule : serial_sender

// >>> dv/uart_autobaud_and_break_wake_test.sv
`timescale 1ns/1ps
module uart_autobaud_and_break_wake_test
    import autobaud_pkg::*;
;
    localparam int bit_cyc = 320;
    int          dv [4] = '{512, 128, 128, 32};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wvalid = 1'b0;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        receiver_busy = 1'b0;
    wire logic   awready, wready, bvalid, arready, rvalid, hold_idle, irq, line;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    logic [31:0] rdat;
    logic [1:0]  rsp;
    int          n_errors = 0;
    int          checks = 0;
    int          cycles = 0;

    always #12.5 aclk = ~aclk;

    uart_autobaud_and_break_wake DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .serial_receive_line(line), .rx_char(8'hA5), .receiver_busy(receiver_busy),
        .receiver_hold_idle(hold_idle), .receive_irq_flag(irq)
    );
    serial_sender tx (.aclk(aclk), .line(line));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // prescaler restarts with the count, but a tick can meet the fifth edge and be dropped, so a count may land one below
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : chk_rng
    // ready lines stay high, so bready and rready never toggle
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rdat = rdata;
        rsp = rresp;
    endtask : axi_rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        axi_rd(a);
        chk(rdat & m, e);
    endtask : rd_chk
    task automatic calibrate(input logic [1:0] s, input logic wake);
        int exp;
        exp = 1 + 8 * bit_cyc / dv[s];
        axi_wr(ctrl_addr, {28'h0, s[0], s[1], wake, 1'b1});
        // hold flag is registered one edge after the write lands
        @(posedge aclk);
        chk(32'(hold_idle), 32'h0000_0001);
        if (wake) begin
            tx.brk(bit_cyc);
            tx.send(16'h0001, 1, bit_cyc);
            rd_chk(rx_data_addr, 32'h0000_00FF, 32'h0000_00A5);
        end else begin
            rd_chk(status_addr, 32'h0000_0007, 32'h0000_0000);
        end
        tx.sync_char(bit_cyc);
        axi_rd(divisor_addr);
        chk_rng(rdat, exp - 1, exp + 1);
        if (s == 2'b00) chk(rdat & 32'h0000_FF00, 32'h0000_0000);
        rd_chk(ctrl_addr, 32'h0000_0003, 32'h0000_0000);
        rd_chk(status_addr, 32'h0000_0001, 32'h0000_0001);
        rd_chk(rx_data_addr, 32'h0000_00FF, 32'h0000_00A5);
        rd_chk(status_addr, 32'h0000_0001, 32'h0000_0000);
        $display("test calibration %0d wake %0d done", s, wake);
    endtask : calibrate
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(ctrl_addr, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk(status_addr, 32'h0000_0007, 32'h0000_0002);
        axi_rd(8'h10);
        chk(32'(rsp), 32'(resp_slverr));
        chk(rdat, 32'h0000_0000);
        axi_wr(divisor_addr, 32'h0000_1234);
        chk(32'(rsp), 32'(resp_okay));
        rd_chk(divisor_addr, 32'h0000_FFFF, 32'h0000_1234);
        axi_wr(8'h10, 32'h0000_0000);
        chk(32'(rsp), 32'(resp_slverr));
        axi_wr(ctrl_addr, 32'h0000_0080);
        rd_chk(ctrl_addr, 32'h0000_0080, 32'h0000_0000);
        $display("test registers done");
        for (int s = 0; s < 4; s++) calibrate(s[1:0], 1'b0);
        receiver_busy <= 1'b1;
        rd_chk(status_addr, 32'h0000_0002, 32'h0000_0000);
        receiver_busy <= 1'b0;
        rd_chk(status_addr, 32'h0000_0002, 32'h0000_0002);
        axi_wr(ctrl_addr, 32'h0000_0002);
        tx.brk(bit_cyc);
        chk(32'(hold_idle), 32'h0000_0001);
        rd_chk(status_addr, 32'h0000_0001, 32'h0000_0001);
        rd_chk(ctrl_addr, 32'h0000_0002, 32'h0000_0002);
        tx.send(16'h0001, 1, bit_cyc);
        rd_chk(ctrl_addr, 32'h0000_0002, 32'h0000_0000);
        rd_chk(rx_data_addr, 32'h0000_00FF, 32'h0000_00A5);
        rd_chk(status_addr, 32'h0000_0001, 32'h0000_0000);
        axi_wr(ctrl_addr, 32'h0000_0002);
        tx.sync_char(bit_cyc);
        rd_chk(status_addr, 32'h0000_0001, 32'h0000_0001);
        rd_chk(ctrl_addr, 32'h0000_0002, 32'h0000_0000);
        rd_chk(rx_data_addr, 32'h0000_00FF, 32'h0000_00A5);
        $display("test wake done");
        axi_wr(ctrl_addr, 32'h0000_0012);
        tx.brk(bit_cyc);
        tx.send(16'h0001, 1, bit_cyc);
        rd_chk(status_addr, 32'h0000_0001, 32'h0000_0000);
        axi_wr(ctrl_addr, 32'h0000_0000);
        $display("test synchronous mode done");
        calibrate(2'b11, 1'b1);
        wrap_up();
    end
endmodule : uart_autobaud_and_break_wake_test
